// ### rtl/icy_map.svh
// Constants of the instruction-cycle core: register offsets, field positions,
// reset values and timing counts.
// Assumes it is included by bare name from files under rtl/.
// How it works
// - Every instruction cycle is exactly four system clocks, so 8MHz gives 0.5us per cycle.
// - Plain instructions take one cycle; jump, call, return and table read take two.
// - Writing the program counter low byte jumps to the new address and costs one more cycle.
// - A skip costs one cycle when not taken and one more cycle when taken.
// - Skips test a data byte or one bit and then run or pass over the next instruction.
// - Addition sets carry above 255 and subtraction sets carry as a borrow below 0.
// - Increment and decrement change a data byte by one and store to memory or accumulator.
// - AND, OR, XOR and complement set the zero flag on a zero result, in accumulator and memory forms alike.
// - Add, subtract, AND, OR and XOR use the accumulator as one operand; memory forms write the result back to the byte read.
// - Rotates shift one place left or right, and through-carry forms swap the edge bit with carry.
// - Bit set and clear read the byte, change one bit and write the byte back.
// - Moves exist from memory to accumulator, accumulator to memory and constant to accumulator.
// - A call saves its return address, return resumes after the call, a jump saves nothing.
// - A table read fetches a program memory word, writes its low byte to data byte m and keeps its high byte in the table register.
// - A halt instruction powers the core down and a separate one clears the watchdog.
// - Interrupt return also sets the global interrupt enable; plain return leaves it alone.
`ifndef ICY_MAP_SVH
`define ICY_MAP_SVH
`define ICY_CLK_MHZ 40
`define ICY_SYS_MHZ 8
`define ICY_INSTR_CLOCKS 4
`define ICY_INSTR_NS (1000 * `ICY_INSTR_CLOCKS / `ICY_SYS_MHZ)
`define ICY_PC_W 12
`define ICY_STACK_DEPTH 8
`define ICY_PC_LOW_ADDR 8'h06
`define ICY_TABLE_PAGE 4'hf
`define ICY_NOP_WORD 16'h0000
`define ICY_REG_CTRL 3'h0
`define ICY_REG_STATUS 3'h1
`define ICY_REG_PC 3'h2
`define ICY_REG_ACC 3'h3
`define ICY_REG_TABLE 3'h4
`define ICY_CTRL_RUN 0
`define ICY_CTRL_GIE 1
`define ICY_ST_HALT 0
`define ICY_ST_ZERO 1
`define ICY_ST_CARRY 2
`define ICY_ST_GIE 3
`define ICY_ST_RUN 4
`define ICY_RST_CTRL 32'h0000_0000
`endif

// ### rtl/icy_pkg.sv
// Types of the instruction-cycle core: instruction classes, ALU and misc codes.
// Assumes nothing of its surroundings.
package icy_pkg;
  typedef enum logic [3:0] {
    CLS_MISC = 4'h0, CLS_MOVE = 4'h1, CLS_ALU_MA = 4'h2, CLS_ALU_MM = 4'h3,
    CLS_ALU_IMM = 4'h4, CLS_BIT = 4'h5, CLS_SKIP_BIT = 4'h6, CLS_SKIP_Z = 4'h7,
    CLS_JUMP = 4'h8, CLS_CALL = 4'h9
  } icy_class_t;
  typedef enum logic [3:0] {
    ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBC = 4'h3,
    ALU_AND = 4'h4, ALU_OR = 4'h5, ALU_XOR = 4'h6, ALU_INV = 4'h7,
    ALU_INC = 4'h8, ALU_DECR = 4'h9, ALU_ROR = 4'ha, ALU_ROL = 4'hb,
    ALU_RORC = 4'hc, ALU_ROLC = 4'hd, ALU_CLR = 4'he, ALU_PASS = 4'hf
  } icy_alu_t;
  typedef enum logic [3:0] {
    MISC_NOP = 4'h0, MISC_HALT = 4'h1, MISC_CLRWDT = 4'h2, MISC_RETURN = 4'h3,
    MISC_IRET = 4'h4, MISC_TABRD = 4'h5
  } icy_misc_t;
  typedef enum logic [1:0] {
    MOVE_TO_ACC = 2'h0, MOVE_TO_MEM = 2'h1, MOVE_IMM = 2'h2
  } icy_move_t;
  typedef enum logic [1:0] {
    PH_ADDR = 2'b00, PH_WAIT = 2'b01, PH_READ = 2'b10, PH_EXEC = 2'b11
  } icy_phase_t;
endpackage

// ### rtl/icy_alu.sv
// Accumulator-centred ALU: add, subtract, AND, OR and XOR take the accumulator and a byte, the rest only the byte.
// Assumes a purely combinational use inside the core.
`timescale 1ns/1ps
`default_nettype none
module icy_alu
  import icy_pkg::*;
(
  input wire icy_alu_t op_in,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] opnd_in,
  input wire logic carry_in,
  output logic [7:0] result_out,
  output logic carry_out,
  output logic carry_we_out
);
  logic [8:0] wide;
  // Nine-bit sums carry the overflow and the borrow in their top bit.
  always_comb begin
    wide = 9'h000;
    carry_we_out = 1'b0;
    result_out = opnd_in;
    carry_out = carry_in;
    unique case (op_in)
      ALU_ADD, ALU_ADC: begin
        wide = {1'b0, acc_in} + {1'b0, opnd_in} + {8'h00, (op_in == ALU_ADC) & carry_in};
        result_out = wide[7:0];
        carry_out = wide[8];
        carry_we_out = 1'b1;
      end
      ALU_SUB, ALU_SBC: begin
        wide = {1'b0, acc_in} - {1'b0, opnd_in} - {8'h00, (op_in == ALU_SBC) & carry_in};
        result_out = wide[7:0];
        carry_out = wide[8];
        carry_we_out = 1'b1;
      end
      ALU_AND: result_out = acc_in & opnd_in;
      ALU_OR: result_out = acc_in | opnd_in;
      ALU_XOR: result_out = acc_in ^ opnd_in;
      ALU_INV: result_out = ~opnd_in;
      ALU_INC: result_out = opnd_in + 8'h01;
      ALU_DECR: result_out = opnd_in - 8'h01;
      ALU_ROR: result_out = {opnd_in[0], opnd_in[7:1]};
      ALU_ROL: result_out = {opnd_in[6:0], opnd_in[7]};
      ALU_RORC: begin
        result_out = {carry_in, opnd_in[7:1]};
        carry_out = opnd_in[0];
        carry_we_out = 1'b1;
      end
      ALU_ROLC: begin
        result_out = {opnd_in[6:0], carry_in};
        carry_out = opnd_in[7];
        carry_we_out = 1'b1;
      end
      ALU_CLR: result_out = 8'h00;
      ALU_PASS: result_out = opnd_in;
    endcase
  end
endmodule
`default_nettype wire

// ### rtl/icy_stack.sv
// Return-address stack for calls and returns.
// Assumes push and pop are never asked in the same cycle; overflow wraps.
`timescale 1ns/1ps
`default_nettype none
module icy_stack #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic [WIDTH-1:0] data_in,
  output logic [WIDTH-1:0] top_out
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] ptr_q;
  // Pointer names the next free slot; the top is the slot below it.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ptr_q <= '0;
    end else if (push_in) begin
      ptr_q <= ptr_q + 1'b1;
    end else if (pop_in) begin
      ptr_q <= ptr_q - 1'b1;
    end
  end
  // Storage has no reset because software never reads an empty stack.
  always_ff @(posedge clock_in) begin
    if (push_in) begin
      mem_q[ptr_q] <= data_in;
    end
  end
  assign top_out = mem_q[ptr_q - 1'b1];
endmodule
`default_nettype wire

// ### rtl/icy_core.sv
// Instruction-cycle core: four-clock cycles, prefetch, skips, calls, table reads.
// Assumes synchronous program and data memories with one clock of read latency
// and an Avalon-MM master for the control and status registers.
//
// Our own choices: the register offsets and the Avalon-MM slave port.
`include "icy_map.svh"
`timescale 1ns/1ps
`default_nettype none
module icy_core
  import icy_pkg::*;
#(
  parameter int PC_W = `ICY_PC_W,
  parameter int STACK_DEPTH = `ICY_STACK_DEPTH
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [4:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [3:0] byteenable_in,
  input wire logic [31:0] writedata_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  output logic [PC_W-1:0] pmem_addr_out,
  input wire logic [15:0] pmem_data_in,
  output logic [7:0] dmem_addr_out,
  output logic [7:0] dmem_wdata_out,
  output logic dmem_we_out,
  input wire logic [7:0] dmem_rdata_in,
  input wire logic wake_in,
  output logic halted_out,
  output logic wdt_clear_out
);
  // Clocks per instruction cycle, tied to the 8MHz system rate figure.
  localparam int CYCLE_CLOCKS = `ICY_INSTR_CLOCKS;
  localparam int CYCLE_NS = `ICY_INSTR_NS;

  icy_phase_t ph_q;
  logic run_q, gie_q, zero_q, carry_q, flush_q, tbl_pend_q;
  logic [PC_W-1:0] pc_q;
  logic [15:0] ir_q, fetch_q;
  logic [7:0] acc_q, opnd_q, tbl_hi_q, tbl_m_q;
  logic [31:0] readdata_q;
  logic wait_q;
  logic en;

  // Decoded fields of the executing word.
  icy_class_t cls;
  logic [3:0] sub;
  logic [7:0] m;
  icy_alu_t alu_op;
  logic [7:0] alu_b, alu_y, bit_y;
  logic alu_c, alu_cwe;
  logic [7:0] stk_unused;
  logic [PC_W-1:0] stk_top;

  // Execute-phase decisions.
  logic wr_acc, wr_mem, wr_zero, skip, jump, push, pop, halt, clrwdt, interrupt_return, tabrd;
  logic [7:0] res;
  logic [PC_W-1:0] target;

  // The word that follows a transfer is killed: it decodes as an empty cycle.
  assign cls = flush_q ? CLS_MISC : icy_class_t'(ir_q[15:12]);
  assign sub = flush_q ? 4'h0 : ir_q[11:8];
  assign m = ir_q[7:0];
  assign en = run_q & ~halted_out;
  assign alu_op = (cls == CLS_MOVE) ? ALU_PASS : icy_alu_t'(sub);
  assign alu_b = (cls == CLS_ALU_IMM || (cls == CLS_MOVE && sub[1:0] == MOVE_IMM)) ? m : opnd_q;
  assign stk_unused = 8'h00;

  // Bit set or clear touches only the chosen bit of the byte read back.
  function automatic logic [7:0] put_bit(input logic [7:0] b, input logic [2:0] i, input logic v);
    logic [7:0] r;
    r = b;
    r[i] = v;
    return r;
  endfunction

  icy_alu u_alu (
    .op_in(alu_op),
    .acc_in(acc_q),
    .opnd_in(alu_b),
    .carry_in(carry_q),
    .result_out(alu_y),
    .carry_out(alu_c),
    .carry_we_out(alu_cwe)
  );

  icy_stack #(.WIDTH(PC_W), .DEPTH(STACK_DEPTH)) u_stack (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .push_in(push & en & (ph_q == PH_EXEC)),
    .pop_in(pop & en & (ph_q == PH_EXEC)),
    .data_in(pc_q),
    .top_out(stk_top)
  );

  assign bit_y = put_bit(opnd_q, sub[2:0], sub[3]);

  // Decode of the executing word; results go to the accumulator or back to data byte m.
  always_comb begin
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    wr_zero = 1'b0;
    skip = 1'b0;
    jump = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    halt = 1'b0;
    clrwdt = 1'b0;
    interrupt_return = 1'b0;
    tabrd = 1'b0;
    res = alu_y;
    target = ir_q[PC_W-1:0];
    unique case (cls)
      CLS_MISC: begin
        halt = (sub == MISC_HALT);
        clrwdt = (sub == MISC_CLRWDT);
        pop = (sub == MISC_RETURN) || (sub == MISC_IRET);
        jump = pop;
        interrupt_return = (sub == MISC_IRET);
        tabrd = (sub == MISC_TABRD);
        target = stk_top;
      end
      CLS_MOVE: begin
        wr_acc = (sub[1:0] != MOVE_TO_MEM);
        wr_mem = (sub[1:0] == MOVE_TO_MEM);
        res = (sub[1:0] == MOVE_TO_MEM) ? acc_q : alu_y;
      end
      CLS_ALU_MA, CLS_ALU_IMM: begin
        wr_acc = 1'b1;
        wr_zero = (alu_op < ALU_ROR) || (alu_op == ALU_CLR);
      end
      CLS_ALU_MM: begin
        wr_mem = 1'b1;
        wr_zero = (alu_op < ALU_ROR) || (alu_op == ALU_CLR);
      end
      CLS_BIT: begin
        wr_mem = 1'b1;
        res = bit_y;
      end
      CLS_SKIP_BIT: skip = (opnd_q[sub[2:0]] == sub[3]);
      CLS_SKIP_Z: skip = (opnd_q == 8'h00);
      CLS_JUMP: jump = 1'b1;
      CLS_CALL: begin
        jump = 1'b1;
        push = 1'b1;
      end
      default: ;
    endcase
  end

  // Phase counter: four clocks make one instruction cycle and it stops while halted.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ph_q <= PH_ADDR;
    end else if (en) begin
      ph_q <= icy_phase_t'(ph_q + 2'b01);
    end
  end

  // Fetch side: the next word is prefetched while the current one executes.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pmem_addr_out <= '0;
      fetch_q <= `ICY_NOP_WORD;
      ir_q <= `ICY_NOP_WORD;
      pc_q <= '0;
      flush_q <= 1'b0;
    end else if (en) begin
      if (ph_q == PH_ADDR) begin
        pmem_addr_out <= tbl_pend_q ? {`ICY_TABLE_PAGE, acc_q} : pc_q;
      end
      if (ph_q == PH_READ) begin
        fetch_q <= pmem_data_in;
      end
      if (ph_q == PH_EXEC) begin
        // After a transfer the prefetched word is loaded but killed by flush_q.
        // The table cycle keeps the word after the table read for the next cycle.
        if (!tbl_pend_q) begin
          ir_q <= fetch_q;
        end
        flush_q <= jump | skip | tabrd | (wr_mem & (m == `ICY_PC_LOW_ADDR));
        if (jump) begin
          pc_q <= target;
        end else if (wr_mem && m == `ICY_PC_LOW_ADDR) begin
          pc_q <= {pc_q[PC_W-1:8], res};
        end else if (skip) begin
          pc_q <= pc_q + 1'b1;
        end else if (!tabrd) begin
          pc_q <= pc_q + 1'b1;
        end
      end
    end
  end

  // Table read: the empty second cycle fetches the table word instead of code.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      tbl_pend_q <= 1'b0;
      tbl_m_q <= 8'h00;
      tbl_hi_q <= 8'h00;
    end else if (en && ph_q == PH_EXEC) begin
      tbl_pend_q <= tabrd;
      tbl_m_q <= m;
      if (tbl_pend_q) begin
        tbl_hi_q <= fetch_q[15:8];
      end
    end
  end

  // Data side: operand address at cycle start, read two clocks later, write at the end.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      dmem_addr_out <= 8'h00;
      dmem_wdata_out <= 8'h00;
      dmem_we_out <= 1'b0;
      opnd_q <= 8'h00;
    end else begin
      dmem_we_out <= 1'b0;
      if (en && ph_q == PH_ADDR) begin
        dmem_addr_out <= m;
      end
      if (en && ph_q == PH_READ) begin
        // The low program counter byte reads as the counter itself.
        opnd_q <= (m == `ICY_PC_LOW_ADDR) ? pc_q[7:0] : dmem_rdata_in;
      end
      if (en && ph_q == PH_EXEC) begin
        if (tbl_pend_q) begin
          dmem_addr_out <= tbl_m_q;
          dmem_wdata_out <= fetch_q[7:0];
          dmem_we_out <= 1'b1;
        end else if (wr_mem && m != `ICY_PC_LOW_ADDR) begin
          dmem_wdata_out <= res;
          dmem_we_out <= 1'b1;
        end
      end
    end
  end

  // Accumulator and flags change only at the end of an executing cycle.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      acc_q <= 8'h00;
      zero_q <= 1'b0;
      carry_q <= 1'b0;
    end else if (en && ph_q == PH_EXEC) begin
      if (wr_acc) begin
        acc_q <= res;
      end
      if (wr_zero) begin
        zero_q <= (res == 8'h00);
      end
      if (alu_cwe && (cls == CLS_ALU_MA || cls == CLS_ALU_MM || cls == CLS_ALU_IMM)) begin
        carry_q <= alu_c;
      end
    end
  end

  // Power-down and watchdog strobes; the wake input ends a halt.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      halted_out <= 1'b0;
      wdt_clear_out <= 1'b0;
    end else begin
      wdt_clear_out <= en && (ph_q == PH_EXEC) && clrwdt;
      if (en && ph_q == PH_EXEC && halt) begin
        halted_out <= 1'b1;
      end else if (wake_in) begin
        halted_out <= 1'b0;
      end
    end
  end

  // Global interrupt enable: interrupt return sets it and wins over a bus write.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      gie_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      if (write_in && !wait_q && address_in[4:2] == `ICY_REG_CTRL && byteenable_in[0]) begin
        run_q <= writedata_in[`ICY_CTRL_RUN];
        gie_q <= writedata_in[`ICY_CTRL_GIE];
      end
      if (en && ph_q == PH_EXEC && interrupt_return) begin
        gie_q <= 1'b1;
      end
    end
  end

  // Avalon slave: every access waits exactly one clock, unmapped reads give zero.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wait_q <= 1'b1;
      readdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= !((read_in || write_in) && wait_q);
      if (read_in && wait_q) begin
        unique case (address_in[4:2])
          `ICY_REG_CTRL: readdata_q <= {30'h0, gie_q, run_q};
          `ICY_REG_STATUS: readdata_q <= {27'h0, run_q, gie_q, carry_q, zero_q, halted_out};
          `ICY_REG_PC: readdata_q <= {{(32 - PC_W){1'b0}}, pc_q};
          `ICY_REG_ACC: readdata_q <= {24'h0, acc_q};
          `ICY_REG_TABLE: readdata_q <= {24'h0, tbl_hi_q};
          default: readdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign waitrequest_out = wait_q;
  assign readdata_out = readdata_q;
endmodule
`default_nettype wire

// ### sim/icy_core_checker.sv
// Concurrent checks on the ports of the instruction-cycle core.
// Assumes it is bound to icy_core and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module icy_core_checker #(
  parameter int PC_W = 12
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic waitrequest_out,
  input wire logic [PC_W-1:0] pmem_addr_out,
  input wire logic [7:0] dmem_addr_out,
  input wire logic dmem_we_out,
  input wire logic wake_in,
  input wire logic halted_out,
  input wire logic wdt_clear_out
);
  // One clock domain, so clock and reset are given once for all checks.
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  // A request that the slave has not answered yet.
  sequence s_req_seen;
    (read_in || write_in) && waitrequest_out;
  endsequence
  // A fetch address stands for the rest of its four-clock cycle.
  sequence s_addr_hold;
    $stable(pmem_addr_out) [*3];
  endsequence
  // Two clocks of power-down, so the edge that entered it is not judged.
  sequence s_halted_two;
    halted_out ##1 halted_out;
  endsequence
  chk_bus_answer: assert property (s_req_seen |=> !waitrequest_out)
    else $error("bus answer not one clock after request");
  chk_wait_once: assert property (!waitrequest_out |=> waitrequest_out)
    else $error("waitrequest low for more than one clock");
  chk_fetch_hold: assert property ($changed(pmem_addr_out) |=> s_addr_hold)
    else $error("fetch address changed inside a cycle");
  chk_write_spacing: assert property (dmem_we_out |=> !dmem_we_out [*3])
    else $error("two data writes inside one cycle");
  chk_pcl_nowrite: assert property (dmem_we_out |-> dmem_addr_out != 8'h06)
    else $error("program counter low byte written to memory");
  chk_wdt_pulse: assert property (wdt_clear_out |=> !wdt_clear_out [*3])
    else $error("watchdog clear pulse too long");
  chk_halt_hold: assert property (halted_out && !wake_in |=> halted_out)
    else $error("power-down left without wake");
  chk_halt_quiet: assert property (s_halted_two |-> !dmem_we_out && $stable(pmem_addr_out))
    else $error("core active while powered down");
endmodule
bind icy_core icy_core_checker #(.PC_W(PC_W)) u_chk (.clock_in(clock_in), .rst_in(rst_in),
  .read_in(read_in), .write_in(write_in), .waitrequest_out(waitrequest_out),
  .pmem_addr_out(pmem_addr_out), .dmem_addr_out(dmem_addr_out), .dmem_we_out(dmem_we_out),
  .wake_in(wake_in), .halted_out(halted_out), .wdt_clear_out(wdt_clear_out));
`default_nettype wire

// ### sim/icy_mem_model.sv
// Program and data memory beside the core, one clock of read latency each.
// Assumes the bench loads both arrays while the core is held in reset.
`timescale 1ns/1ps
`default_nettype none
module icy_mem_model #(
  parameter int PC_W = 12
) (
  input wire logic clock_in,
  input wire logic [PC_W-1:0] pmem_addr_in,
  output logic [15:0] pmem_data_out,
  input wire logic [7:0] dmem_addr_in,
  input wire logic [7:0] dmem_wdata_in,
  input wire logic dmem_we_in,
  output logic [7:0] dmem_rdata_out
);
  logic [15:0] prog [0:(1<<PC_W)-1];
  logic [7:0] data [0:255];
  // Table constants share the code array; a data read during a write sees the old byte.
  always @(posedge clock_in) begin
    pmem_data_out <= prog[pmem_addr_in];
    dmem_rdata_out <= data[dmem_addr_in];
    if (dmem_we_in) begin
      data[dmem_addr_in] <= dmem_wdata_in;
    end
  end
endmodule
`default_nettype wire

// ### sim/icy_core_tb.sv
// Self-checking bench: runs one program three times with corner and random operands.
// Assumes the memory model answers each address one clock later.
`timescale 1ns/1ps
`default_nettype none
module icy_core_tb;
  logic clock_in = 0;
  logic rst_in = 1;
  logic read_in = 0;
  logic write_in = 0;
  logic wake_in = 0;
  logic [4:0] address_in = 5'h00;
  logic [31:0] writedata_in = 32'h0000_0000;
  logic [31:0] readdata_out, rd;
  logic waitrequest_out, dmem_we_out, halted_out, wdt_clear_out, zf;
  logic [11:0] pmem_addr_out;
  logic [15:0] pmem_data_in, rt;
  logic [7:0] dmem_addr_out, dmem_wdata_out, dmem_rdata_in, ra, rb, rc;
  logic [2:0] b, b2, b3;
  logic [15:0] w_v[$], e_v[$];
  int w_t[$], e_g[$];
  int n_errors = 0, check_count = 0, cyc = 0, n_wdt = 0, i;

  icy_core uut (.clock_in(clock_in), .rst_in(rst_in), .address_in(address_in), .read_in(read_in),
    .write_in(write_in), .byteenable_in(4'hf), .writedata_in(writedata_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .pmem_addr_out(pmem_addr_out), .pmem_data_in(pmem_data_in),
    .dmem_addr_out(dmem_addr_out), .dmem_wdata_out(dmem_wdata_out), .dmem_we_out(dmem_we_out),
    .dmem_rdata_in(dmem_rdata_in), .wake_in(wake_in), .halted_out(halted_out), .wdt_clear_out(wdt_clear_out));
  icy_mem_model u_mem (.clock_in(clock_in), .pmem_addr_in(pmem_addr_out), .pmem_data_out(pmem_data_in),
    .dmem_addr_in(dmem_addr_out), .dmem_wdata_in(dmem_wdata_out), .dmem_we_in(dmem_we_out),
    .dmem_rdata_out(dmem_rdata_in));

  // 40 MHz system clock.
  always #12.5 clock_in = ~clock_in;

  // Log every data write with its clock count; the gaps reveal instruction lengths.
  always @(posedge clock_in) begin
    cyc++;
    if (dmem_we_out === 1'b1) begin
      w_t.push_back(cyc);
      w_v.push_back({dmem_addr_out, dmem_wdata_out});
    end
    if (wdt_clear_out === 1'b1) n_wdt++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One Avalon transfer; the request stands until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    int k;
    @(posedge clock_in);
    read_in <= !wr;
    write_in <= wr;
    address_in <= a;
    writedata_in <= wd;
    for (k = 0; k < 50; k++) begin
      @(posedge clock_in);
      if (waitrequest_out === 1'b0) break;
    end
    if (k == 50) begin
      n_errors++;
      end_sim();
    end
    rd = readdata_out;
    read_in <= 1'b0;
    write_in <= 1'b0;
  endtask

  // Code: arithmetic, rotates, jump, skips, bit ops, nested calls, counter-low write, table read, halt.
  task automatic load();
    logic [15:0] p [0:29];
    p = '{16'h1020, 16'h2021, 16'h1140, 16'h2d40, 16'h1141, {8'h42, rc}, 16'h1142, 16'h2c42,
      16'h1143, 16'h800c, 16'h114f, 16'h114f, 16'h1144, 16'h2644, 16'h7022, 16'h114f, 16'h1145,
      {4'h6, ~rb[b], b, 8'h21}, 16'h1146, {4'h5, 1'b1, b2, 8'h23}, {4'h5, 1'b0, b3, 8'h23},
      16'h9022, 16'h1148, 16'h121a, 16'h1106, 16'h114f, 16'h1149, 16'h052a, 16'h0200, 16'h0100};
    for (int k = 0; k < 4096; k++) u_mem.prog[k] = (k < 30) ? p[k] : 16'h0000;
    for (int k = 0; k < 256; k++) u_mem.data[k] = 8'h00;
    u_mem.prog[34] = 16'h3823;
    u_mem.prog[35] = 16'h9026;
    u_mem.prog[36] = 16'h0400;
    u_mem.prog[38] = 16'h0300;
    u_mem.prog[12'hf1a] = rt;
    u_mem.data[8'h20] = ra;
    u_mem.data[8'h21] = rb;
    u_mem.data[8'h23] = rc;
  endtask

  // Expected data writes and clock gaps; a gap of 0 is not compared.
  function automatic void plan();
    logic [8:0] s9, d9;
    logic [7:0] r1, r3, m;
    s9 = {1'b0, ra} + {1'b0, rb};
    r1 = {s9[6:0], s9[8]};
    d9 = {1'b0, r1} - {1'b0, rc};
    r3 = {d9[8], d9[7:1]};
    m = (rc | (8'h01 << b2)) & ~(8'h01 << b3);
    zf = (m + 8'h01) == 8'h00;
    e_v = '{{8'h40, s9[7:0]}, {8'h41, r1}, {8'h42, d9[7:0]}, {8'h43, r3}, {8'h44, r3}, 16'h4500, 16'h4600,
      {8'h23, rc | (8'h01 << b2)}, {8'h23, m}, {8'h23, m + 8'h01}, 16'h4800, 16'h491a, {8'h2a, rt[7:0]}};
    e_g = '{0, 8, 8, 8, 12, 16, 8, 4, 4, 12, 28, 16, 0};
  endfunction

  initial begin
    void'($urandom(95));
    for (int it = 0; it < 3; it++) begin
      {ra, rb, rc} = it == 0 ? 24'hff0101 : it == 1 ? 24'h000080 : 24'($urandom);
      {b, b2, b3, rt} = 25'($urandom);
      @(posedge clock_in);
      rst_in <= 1'b1;
      repeat (8) @(posedge clock_in);
      load();
      w_t.delete();
      w_v.delete();
      n_wdt = 0;
      rst_in <= 1'b0;
      bus(0, 5'h00, 32'h0);
      chk(rd, 32'h0);
      bus(1, 5'h04, 32'h1f);
      bus(0, 5'h04, 32'h0);
      chk(rd & 32'h19, 32'h0);
      bus(0, 5'h14, 32'h0);
      chk(rd, 32'h0);
      bus(1, 5'h00, 32'h1);
      for (i = 0; i < 2000 && halted_out !== 1'b1; i++) @(posedge clock_in);
      if (i == 2000) begin
        n_errors++;
        end_sim();
      end
      plan();
      chk(32'(w_v.size()), 32'(e_v.size()));
      for (i = 0; i < e_v.size() && i < w_v.size(); i++) begin
        chk({16'h0, w_v[i]}, {16'h0, e_v[i]});
        if (e_g[i] > 0) chk(32'(w_t[i] - w_t[i-1]), 32'(e_g[i]));
      end
      chk(32'(n_wdt), 32'h1);
      bus(0, 5'h0c, 32'h0);
      chk(rd, 32'h1a);
      bus(0, 5'h04, 32'h0);
      chk(rd & 32'h1b, {27'h0, 2'b11, 1'b0, zf, 1'b1});
      bus(0, 5'h10, 32'h0);
      chk(rd, {24'h0, rt[15:8]});
      wake_in <= 1'b1;
      @(posedge clock_in);
      wake_in <= 1'b0;
      repeat (4) @(posedge clock_in);
      chk({31'h0, halted_out}, 32'h0);
    end
    end_sim();
  end
endmodule
`default_nettype wire
